// *** design/dct_dead.sv ***
// deadband generator making true and complementary outputs from one level
`timescale 1ns/1ps
module dct_dead (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic level_in,
  input wire logic comp_en_in,
  input wire logic kill_in,
  input wire logic [7:0] dead_in,
  output logic true_out,
  output logic comp_out
);
  typedef struct packed {
    logic last;
    logic [7:0] gap;
    logic t;
    logic c;
  } dct_dead_t;
  dct_dead_t d_reg;
  dct_dead_t d_next;
  always_comb begin
    d_next = d_reg;
    d_next.last = level_in;
    if (level_in != d_reg.last) begin
      // both sides low through the gap, so edges never overlap
      d_next.gap = dead_in; // RL3
      d_next.t = 1'b0;
      d_next.c = 1'b0;
    end else if (d_reg.gap != 8'h00) begin
      d_next.gap = d_reg.gap - 8'h01;
    end else begin
      d_next.t = level_in;
      d_next.c = ~level_in & comp_en_in; // RL3
    end
    if (kill_in) begin
      d_next.t = 1'b0; // RL11
      d_next.c = 1'b0; // RL11
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end
  assign true_out = d_reg.t;
  assign comp_out = d_reg.c;
endmodule

// *** design/dct_pkg.sv ***
// package of constants and types for the down-count timer pwm unit
// Notes on behaviour
// RL1 - the counter is sixteen bits wide and only ever counts down.
// RL2 - the unit drives a compare output and a terminal count output.
// RL3 - an optional complementary compare output has a deadband gap.
// RL4 - the comparator is set to lt, le, eq, ge or gt of the compare value.
// RL5 - the period is loaded on start, on reset input and at terminal count.
// RL6 - in one-shot mode the counter runs one period and then halts.
// RL7 - run mode is free running, one shot or gated by the enable input.
// RL8 - in gated mode the counter moves only while enable is asserted.
// RL9 - a reset input reloads the counter, a capture input latches it.
// RL10 - a capture stores the full sixteen-bit count for firmware to read.
// RL11 - while kill is active both compare outputs are forced inactive.
// RL12 - the counting clock is chosen from several tick sources.
// RL13 - terminal count pulses for one count tick when zero is reloaded; the code pulses tc_out for one clock cycle with any tick source.
// RL14 - firmware can read the live count at any time without disturbing it.
package dct_pkg;
  localparam int CNT_W = 16;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h1;
  localparam logic [3:0] ADDR_CMP = 4'h2;
  localparam logic [3:0] ADDR_DEAD = 4'h3;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_CAPT = 4'h5;
  localparam logic [3:0] ADDR_STAT = 4'h6;
  localparam logic [3:0] ADDR_MASK = 4'h7;
  // ctrl field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_CMP = 3;
  localparam int CTRL_CLK = 6;
  localparam int CTRL_COMP_EN = 8;
  localparam int CTRL_START = 9;
  // status bit positions
  localparam int ST_TC = 0;
  localparam int ST_CAPT = 1;
  localparam int ST_ONESHOT = 2;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] CMP_RST = 16'h8000;
  localparam logic [7:0] DEAD_RST = 8'h00;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [1:0] MODE_GATE = 2'h2;
  localparam logic [2:0] CMP_LT = 3'h0;
  localparam logic [2:0] CMP_LE = 3'h1;
  localparam logic [2:0] CMP_EQ = 3'h2;
  localparam logic [2:0] CMP_GE = 3'h3;
  localparam logic [2:0] CMP_GT = 3'h4;
  localparam logic [1:0] CLK_SYS = 2'h0;
  localparam logic [1:0] CLK_SRC0 = 2'h1;
  localparam logic [1:0] CLK_SRC1 = 2'h2;
  localparam logic [1:0] CLK_SRC2 = 2'h3;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RD = 3'b010,
    BUS_DONE = 3'b100
  } dct_bus_t;
endpackage

// *** design/dct_sync.sv ***
// two flip-flop synchroniser for a vector of fabric inputs
`timescale 1ns/1ps
module dct_sync #(
  parameter int W = 8
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dct_sync_t;
  dct_sync_t s_reg;
  dct_sync_t s_next;
  initial begin
    if (W < 1) begin
      $error("dct_sync width must be at least one");
    end
  end
  always_comb begin
    s_next.meta = async_in;
    s_next.sync = s_reg.meta;
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign sync_out = s_reg.sync;
endmodule

// *** design/dct_timer.sv ***
// top of the down-count timer pwm unit with avalon-mm register slave
`timescale 1ns/1ps
module dct_timer (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic enable_in,
  input wire logic reset_in,
  input wire logic capture_in,
  input wire logic kill_in,
  input wire logic [2:0] clk_src_in,
  output logic cmp_out,
  output logic cmp_n_out,
  output logic tc_out,
  output logic irq_out
);
  import dct_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // fabric inputs are asynchronous to this clock
  logic [6:0] raw_in;
  logic [6:0] syn;
  assign raw_in = {clk_src_in, kill_in, capture_in, reset_in, enable_in};
  dct_sync #(
    .W(7)
  ) u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in(raw_in),
    .sync_out(syn)
  );

  typedef struct packed {
    logic run;
    logic [1:0] mode;
    logic [2:0] cmp_sel;
    logic [1:0] clk_sel;
    logic comp_en;
    logic [15:0] period;
    logic [15:0] cmp_val;
    logic [7:0] dead;
    logic [15:0] count;
    logic [15:0] capt;
    logic [2:0] stat;
    logic [2:0] mask;
    logic halted;
    logic [2:0] src_last;
    logic rst_last;
    logic cap_last;
    logic tc;
    logic irq;
    dct_bus_t bus;
    logic [31:0] rdata;
    logic wait_n;
  } dct_state_t;
  dct_state_t r_reg;
  dct_state_t r_next;

  logic tick;
  logic cmp_hit;
  logic cmp_lvl;
  logic wr_ok;
  logic rd_ok;
  logic start;
  logic [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////
  // count tick: system clock or a rising edge of a fabric source
  always_comb begin
    case (r_reg.clk_sel) // RL12
      CLK_SYS: tick = 1'b1;
      CLK_SRC0: tick = syn[4] & ~r_reg.src_last[0];
      CLK_SRC1: tick = syn[5] & ~r_reg.src_last[1];
      CLK_SRC2: tick = syn[6] & ~r_reg.src_last[2];
      default: tick = 1'b0;
    endcase
  end

  always_comb begin
    case (r_reg.cmp_sel) // RL4
      CMP_LT: cmp_hit = r_reg.count < r_reg.cmp_val;
      CMP_LE: cmp_hit = r_reg.count <= r_reg.cmp_val;
      CMP_EQ: cmp_hit = r_reg.count == r_reg.cmp_val;
      CMP_GE: cmp_hit = r_reg.count >= r_reg.cmp_val;
      CMP_GT: cmp_hit = r_reg.count > r_reg.cmp_val;
      default: cmp_hit = 1'b0;
    endcase
  end
  assign cmp_lvl = cmp_hit & r_reg.run;

  //////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb begin
    case (avs_address_in)
      ADDR_CTRL: rd_mux = {23'h000000, r_reg.comp_en, r_reg.clk_sel,
        r_reg.cmp_sel, r_reg.mode, r_reg.run};
      ADDR_PERIOD: rd_mux = {16'h0000, r_reg.period};
      ADDR_CMP: rd_mux = {16'h0000, r_reg.cmp_val};
      ADDR_DEAD: rd_mux = {24'h000000, r_reg.dead};
      ADDR_COUNT: rd_mux = {16'h0000, r_reg.count}; // RL14
      ADDR_CAPT: rd_mux = {16'h0000, r_reg.capt}; // RL10
      ADDR_STAT: rd_mux = {29'h00000000, r_reg.stat};
      ADDR_MASK: rd_mux = {29'h00000000, r_reg.mask};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // a write is taken in the cycle it is seen and answered one cycle later; a read takes two wait cycles
  assign wr_ok = avs_write_in & (r_reg.bus == BUS_IDLE);
  assign rd_ok = avs_read_in & (r_reg.bus == BUS_RD);
  assign start = wr_ok & (avs_address_in == ADDR_CTRL) &
    avs_byteenable_in[1] & avs_writedata_in[CTRL_START];

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    r_next.src_last = syn[6:4];
    r_next.rst_last = syn[1];
    r_next.cap_last = syn[2];
    r_next.tc = 1'b0;
    r_next.wait_n = 1'b0;

    // bus protocol
    case (r_reg.bus)
      BUS_IDLE: begin
        if (avs_write_in) begin
          r_next.wait_n = 1'b1;
          r_next.bus = BUS_DONE;
        end else if (avs_read_in) begin
          r_next.bus = BUS_RD;
        end
      end
      BUS_RD: begin
        r_next.rdata = rd_mux;
        r_next.wait_n = 1'b1;
        r_next.bus = BUS_DONE;
      end
      BUS_DONE: r_next.bus = BUS_IDLE;
      default: r_next.bus = BUS_IDLE;
    endcase

    // counter
    if (start || (syn[1] && !r_reg.rst_last)) begin
      r_next.count = r_reg.period; // RL5 RL9
      r_next.halted = 1'b0;
    end else if (r_reg.run && !r_reg.halted && tick &&
        (r_reg.mode != MODE_GATE || syn[0])) begin // RL7 RL8
      if (r_reg.count == 16'h0000) begin
        r_next.count = r_reg.period; // RL5
        r_next.tc = 1'b1; // RL13
        r_next.stat[ST_TC] = 1'b1;
        if (r_reg.mode == MODE_ONE) begin
          r_next.halted = 1'b1; // RL6
          r_next.stat[ST_ONESHOT] = 1'b1;
        end
      end else begin
        r_next.count = r_reg.count - 16'h0001; // RL1
      end
    end

    if (syn[2] && !r_reg.cap_last) begin
      r_next.capt = r_reg.count; // RL9 RL10
      r_next.stat[ST_CAPT] = 1'b1;
    end

    // register writes
    if (wr_ok) begin
      case (avs_address_in)
        ADDR_CTRL: begin
          if (avs_byteenable_in[0]) begin
            r_next.run = avs_writedata_in[CTRL_RUN];
            r_next.mode = avs_writedata_in[CTRL_MODE +: 2];
            r_next.cmp_sel = avs_writedata_in[CTRL_CMP +: 3];
            r_next.clk_sel = avs_writedata_in[CTRL_CLK +: 2];
          end
          if (avs_byteenable_in[1]) begin
            r_next.comp_en = avs_writedata_in[CTRL_COMP_EN];
          end
        end
        ADDR_PERIOD: begin
          if (avs_byteenable_in[0]) r_next.period[7:0] = avs_writedata_in[7:0];
          if (avs_byteenable_in[1]) begin
            r_next.period[15:8] = avs_writedata_in[15:8];
          end
        end
        ADDR_CMP: begin
          if (avs_byteenable_in[0]) begin
            r_next.cmp_val[7:0] = avs_writedata_in[7:0];
          end
          if (avs_byteenable_in[1]) begin
            r_next.cmp_val[15:8] = avs_writedata_in[15:8];
          end
        end
        ADDR_DEAD: begin
          if (avs_byteenable_in[0]) r_next.dead = avs_writedata_in[7:0];
        end
        ADDR_MASK: begin
          if (avs_byteenable_in[0]) r_next.mask = avs_writedata_in[2:0];
        end
        default: begin
        end
      endcase
    end

    // read clears status; events of this cycle survive the clear
    if (rd_ok && avs_address_in == ADDR_STAT) begin
      r_next.stat = r_next.stat & ~r_reg.stat;
      // set wins for every event of this cycle, not only tc
      if (r_next.tc) r_next.stat[ST_TC] = 1'b1;
      if (syn[2] && !r_reg.cap_last) r_next.stat[ST_CAPT] = 1'b1;
      if (r_next.halted && !r_reg.halted) begin
        r_next.stat[ST_ONESHOT] = 1'b1;
      end
    end
    r_next.irq = |(r_next.stat & r_next.mask);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
      r_reg.period <= PERIOD_RST;
      r_reg.cmp_val <= CMP_RST;
      r_reg.dead <= DEAD_RST;
      r_reg.stat <= STAT_RST;
      r_reg.mask <= MASK_RST;
      r_reg.bus <= BUS_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare outputs registered inside the deadband stage
  dct_dead u_dead (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .level_in(cmp_lvl),
    .comp_en_in(r_reg.comp_en),
    .kill_in(syn[3]),
    .dead_in(r_reg.dead),
    .true_out(cmp_out), // RL2
    .comp_out(cmp_n_out)
  );

  assign tc_out = r_reg.tc; // RL2
  assign irq_out = r_reg.irq;
  assign avs_readdata_out = r_reg.rdata;
  assign avs_waitrequest_out = ~r_reg.wait_n;
endmodule

// *** tb/dct_fabric.sv ***
// model of the routing fabric making tick sources for the timer
`timescale 1ns/1ps
module dct_fabric (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  output logic [2:0] clk_src_out
);
  logic [3:0] div_reg;
  // sources only move while run_in, so a frozen count can be compared
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      div_reg <= 4'h0;
    end else if (run_in) begin
      div_reg <= div_reg + 4'h1;
    end
  end
  assign clk_src_out = div_reg[3:1];
endmodule

// *** tb/dct_timer_sva.sv ***
// checker of port behaviour of the down-count timer
`timescale 1ns/1ps
module dct_timer_chk (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic kill_in,
  input wire logic cmp_out,
  input wire logic cmp_n_out,
  input wire logic tc_out,
  input wire logic irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_tc_one_cycle: assert property (tc_out |=> !tc_out)
    else $error("tc pulse longer than one cycle");
  // kill passes a two-stage sync, so allow three cycles
  chk_kill_true: assert property (kill_in [*4] |-> !cmp_out)
    else $error("compare output high under kill");
  chk_kill_comp: assert property (kill_in [*4] |-> !cmp_n_out)
    else $error("complementary output high under kill");
  chk_dead_gap: assert property (!(cmp_out && cmp_n_out))
    else $error("true and complementary outputs overlap");
  chk_ack_single: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("waitrequest low too long");
  chk_write_ack: assert property ($rose(avs_write_in) |=>
    !avs_waitrequest_out) else $error("write not answered in time");
  chk_read_ack: assert property ($rose(avs_read_in) |=>
    avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read not answered in time");
  chk_unmapped_zero: assert property (avs_read_in && avs_address_in[3]
    && !avs_waitrequest_out |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  cov_tc: cover property (tc_out);
  cov_irq: cover property ($rose(irq_out));
  cov_comp: cover property (cmp_n_out);
endmodule
//////////////////////////////////////////////////////////////////////
bind dct_timer dct_timer_chk CHK (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .kill_in(kill_in),
  .cmp_out(cmp_out), .cmp_n_out(cmp_n_out), .tc_out(tc_out),
  .irq_out(irq_out));

// *** tb/dct_timer_test.sv ***
// self-checking bench of the down-count timer
`timescale 1ns/1ps
module dct_timer_test;
  import dct_pkg::*;
  logic clk, rst_n, rd, wr, en, rs, cp, kl, srun, wq, co, cn, tc, irq;
  logic [3:0] a;
  logic [31:0] wd, rdat, q, x, y;
  logic [2:0] src;
  int errors, checked, cyc;
  dct_fabric PM (.clock_in(clk), .rst_n_in(rst_n), .run_in(srun),
    .clk_src_out(src));
  dct_timer DUT (.clock_in(clk), .rst_n_in(rst_n), .avs_address_in(a),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .enable_in(en), .reset_in(rs),
    .capture_in(cp), .kill_in(kl), .clk_src_in(src), .cmp_out(co),
    .cmp_n_out(cn), .tc_out(tc), .irq_out(irq));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // a whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // signals are sampled before the edge's updates land
  task automatic bus(input logic w, input logic [3:0] ad,
    input logic [31:0] d);
    a <= ad;
    wr <= w;
    rd <= !w;
    wd <= d;
    // only the bench timeout ends a wait that never answers
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] m, logic [2:0] c,
    logic [1:0] k, logic ce);
    return (32'h1 << CTRL_START) | (32'(ce) << CTRL_COMP_EN) |
      (32'(k) << CTRL_CLK) | (32'(c) << CTRL_CMP) |
      (32'(m) << CTRL_MODE) | 32'h1;
  endfunction
  task automatic t_regs;
    bus(0, ADDR_PERIOD, 0); chk("period", 32'h0000FFFF, q);
    bus(0, ADDR_CMP, 0); chk("cmp", 32'h00008000, q);
    bus(0, ADDR_DEAD, 0); chk("dead", 32'h0, q);
    bus(0, ADDR_MASK, 0); chk("mask", 32'h0, q);
    bus(0, 4'h9, 0); chk("unmapped", 32'h0, q);
    $display("regs test done");
  endtask
  task automatic t_cmp;
    logic e;
    srun <= 0;
    bus(1, ADDR_PERIOD, 32'hA);
    // a real gap so the overlap check sees deadband edges
    bus(1, ADDR_DEAD, 32'h3);
    for (int m = 0; m < 5; m++) begin
      for (int c = 10; c < 12; c++) begin
        e = m == 0 ? 10 < c : m == 1 ? 10 <= c : m == 2 ? 10 == c :
          m == 3 ? 10 >= c : 10 > c;
        bus(1, ADDR_CMP, c);
        bus(1, ADDR_CTRL, ctl(MODE_FREE, m, CLK_SRC0, 1));
        repeat (8) @(posedge clk);
        chk("cmp level", e, co);
        chk("comp level", !e, cn);
        if (e) begin
          kl <= 1;
          repeat (6) @(posedge clk);
          chk("kill true", 0, co);
          chk("kill comp", 0, cn);
          kl <= 0;
        end
      end
    end
    bus(0, ADDR_COUNT, 0); chk("start load", 32'hA, q);
    $display("compare test done");
  endtask
  task automatic t_free;
    int d;
    bus(1, ADDR_PERIOD, 32'h4);
    bus(1, ADDR_MASK, 32'h1 << ST_TC);
    bus(1, ADDR_CTRL, ctl(MODE_FREE, CMP_GE, CLK_SYS, 0));
    d = 0;
    do begin @(posedge clk); d++; end while (tc !== 1'b1 && d < 99);
    d = 0;
    do begin @(posedge clk); d++; end while (tc !== 1'b1 && d < 99);
    chk("tc gap", 5, d);
    chk("irq on", 1, irq);
    bus(0, ADDR_STAT, 0); chk("tc flag", 1, q[ST_TC]);
    bus(1, ADDR_MASK, 0);
    repeat (3) @(posedge clk);
    chk("irq off", 0, irq);
    // stop first, so only the reset input can reload the count
    bus(1, ADDR_CTRL, 0);
    bus(1, ADDR_PERIOD, 32'hFFF);
    rs <= 1;
    repeat (4) @(posedge clk);
    rs <= 0;
    repeat (4) @(posedge clk);
    bus(0, ADDR_COUNT, 0); chk("reset load", 32'hFFF, q);
    bus(1, ADDR_CTRL, ctl(MODE_FREE, CMP_GE, CLK_SYS, 0));
    repeat (4) @(posedge clk);
    x = q;
    cp <= 1;
    repeat (4) @(posedge clk);
    cp <= 0;
    bus(0, ADDR_CAPT, 0);
    y = q;
    bus(0, ADDR_COUNT, 0); chk("capture", 1, y < x && y > q);
    chk("down", 1, q < x);
    bus(0, ADDR_STAT, 0); chk("capt flag", 1, q[ST_CAPT]);
    $display("free run test done");
  endtask
  task automatic t_modes;
    srun <= 1;
    bus(1, ADDR_PERIOD, 32'h6);
    bus(1, ADDR_CTRL, ctl(MODE_ONE, CMP_LT, CLK_SRC1, 0));
    repeat (80) @(posedge clk);
    bus(0, ADDR_COUNT, 0);
    x = q;
    repeat (20) @(posedge clk);
    bus(0, ADDR_COUNT, 0); chk("halted", x, q);
    bus(0, ADDR_STAT, 0); chk("one done", 1, q[ST_ONESHOT]);
    bus(1, ADDR_PERIOD, 32'hFFF);
    en <= 0;
    bus(1, ADDR_CTRL, ctl(MODE_GATE, CMP_LT, CLK_SYS, 0));
    bus(0, ADDR_COUNT, 0);
    x = q;
    repeat (5) @(posedge clk);
    bus(0, ADDR_COUNT, 0); chk("gate hold", x, q);
    en <= 1;
    repeat (5) @(posedge clk);
    bus(0, ADDR_COUNT, 0); chk("gate run", 1, q < x);
    $display("mode test done");
  endtask
  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {rst_n, rd, wr, en, rs, cp, kl, srun} = '0;
    cyc = 0;
    errors = 0;
    checked = 0;
    a = 0;
    wd = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs();
    t_cmp();
    t_free();
    t_modes();
    conclude();
  end
endmodule
